/* rtl/irq_ctrl.sv */
// Purpose: Interrupt enable and flag register bank with combined request
// Assumes: Event inputs are one-cycle pulses synchronous to ref_clk
// Notes:   Core acknowledges a taken interrupt and a return with pulses
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int PIN_COUNT = 8     // Pin change sources
) (
    input  wire logic                 ref_clk,        // System clock
    input  wire logic                 rst,            // Async reset, active high
    input  wire logic [1:0]           reg_addr,       // Register index
    input  wire logic [7:0]           reg_wdata,      // Write data
    input  wire logic                 reg_wr,         // Write strobe
    input  wire logic                 reg_rd,         // Read strobe
    output logic      [7:0]           reg_rdata,      // Read data, cycle after strobe
    input  wire logic                 timer0_ovf,     // Timer0 count overflow pulse
    input  wire logic                 ext_pin,        // External interrupt pin
    input  wire logic [PIN_COUNT-1:0] per_pin_change_flags, // Per-pin change flags
    input  wire logic [7:0]           periph_flags_one, // First peripheral flags
    input  wire logic [7:0]           periph_flags_two, // Second peripheral flags
    input  wire logic                 irq_taken,      // Core vectors to interrupt
    input  wire logic                 return_from_interrupt, // Core returns from handler
    output logic                      irq_req,        // Combined request to core
    output logic      [15:0]          irq_vector      // Vector address for the core
);
    reg_req_s req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    logic [7:0] ctrl;          // bits 7..1 stored, bit 0 unused
    logic [7:0] peripheral_enable_one;
    logic [7:0] peripheral_enable_two;
    logic       ext_pin_edge_select;
    logic       ext_hit;

    edge_detect u_edge (
        .ref_clk (ref_clk),
        .rst     (rst),
        .sig     (ext_pin),
        .rising  (ext_pin_edge_select),
        .hit     (ext_hit)
    );

    wire wr_ctrl = req.wr && req.addr == IDX_INTERRUPT_CONTROL;
    wire wr_one  = req.wr && req.addr == IDX_PERIPHERAL_ENABLE_ONE;
    wire wr_two  = req.wr && req.addr == IDX_PERIPHERAL_ENABLE_TWO;
    wire wr_edge = req.wr && req.addr == IDX_EDGE_CONFIG;

    // RULE_11: summary of pin flags
    wire pin_change_summary_flag = |per_pin_change_flags;

    wire global_irq_enable       = ctrl[BIT_GLOBAL_EN];
    wire peripheral_group_enable = ctrl[BIT_GROUP_EN];
    wire timer0_overflow_flag    = ctrl[BIT_TIMER0_COUNT_FLAG];
    wire ext_pin_irq_flag        = ctrl[BIT_EXT_FLAG];

    // RULE_06 RULE_04: timer0 flag set wins
    wire next_timer0_count_flag = timer0_ovf |
        (wr_ctrl ? reg_wdata[BIT_TIMER0_COUNT_FLAG] : timer0_overflow_flag);
    // RULE_08 RULE_04: external flag set wins
    wire next_ext_flag = ext_hit |
        (wr_ctrl ? reg_wdata[BIT_EXT_FLAG] : ext_pin_irq_flag);

    // RULE_17 RULE_18: core clears or sets global enable
    wire next_global = irq_taken ? 1'b0 :
        return_from_interrupt ? 1'b1 :
        wr_ctrl ? reg_wdata[BIT_GLOBAL_EN] : global_irq_enable;

    wire [7:0] next_ctrl = {next_global,
        wr_ctrl ? reg_wdata[6:3] : ctrl[6:3],
        next_timer0_count_flag, next_ext_flag, 1'b0};

    // RULE_07 RULE_09 RULE_10: core sources gated
    wire core_pending = (ctrl[BIT_TIMER0_COUNT_EN] & timer0_overflow_flag) |
        (ctrl[BIT_EXT_EN] & ext_pin_irq_flag) |
        (ctrl[BIT_PCHG_EN] & pin_change_summary_flag);
    // RULE_13 RULE_14: peripheral sources gated
    wire periph_raw = |(peripheral_enable_one & periph_flags_one) |
        |(peripheral_enable_two & periph_flags_two & ENABLE_TWO_MASK);
    // RULE_02 RULE_03: group enable gate
    wire periph_pending = peripheral_group_enable & periph_raw;
    // RULE_01 RULE_20 RULE_21: combined request
    wire next_irq_req = next_global & (core_pending | periph_pending) & ~irq_taken;

    wire [7:0] ctrl_view = {ctrl[7:1], pin_change_summary_flag};
    wire [7:0] rd_mux =
        req.addr == IDX_INTERRUPT_CONTROL     ? ctrl_view :
        req.addr == IDX_PERIPHERAL_ENABLE_ONE ? peripheral_enable_one :
        req.addr == IDX_PERIPHERAL_ENABLE_TWO ? peripheral_enable_two :
        {7'h00, ext_pin_edge_select};

    // RULE_16: all zero on reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl                  <= RESET_VALUE;
            peripheral_enable_one <= RESET_VALUE;
            peripheral_enable_two <= RESET_VALUE;
            ext_pin_edge_select   <= 1'b0;
            reg_rdata             <= RESET_VALUE;
            irq_req               <= 1'b0;
            irq_vector            <= 16'h0000;
        end else begin
            // RULE_12: summary bit not stored
            ctrl <= next_ctrl;
            if (wr_one) begin
                peripheral_enable_one <= reg_wdata;
            end
            // RULE_15: bit 4 held at zero
            if (wr_two) begin
                peripheral_enable_two <= reg_wdata & ENABLE_TWO_MASK;
            end
            if (wr_edge) begin
                ext_pin_edge_select <= reg_wdata[BIT_EDGE_SEL];
            end
            reg_rdata  <= req.rd ? rd_mux : 8'h00;
            irq_req    <= next_irq_req;
            irq_vector <= IRQ_VECTOR;
        end
    end

    // RULE_01: no request without enable
    AST_GLOBAL_GATE: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
        !global_irq_enable |=> !irq_req || $past(return_from_interrupt) || $past(wr_ctrl))
        else $error("request raised with global enable clear");
    AST_GROUP_GATE: assert property (@(posedge ref_clk) disable iff (rst) // RULE_02
        (global_irq_enable && !peripheral_group_enable && !core_pending && !irq_taken
         && !wr_ctrl && !return_from_interrupt && !timer0_ovf && !ext_hit) |=> !irq_req)
        else $error("peripheral request passed closed group gate");
    AST_TIMER0_COUNT_SET: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
        timer0_ovf |=> timer0_overflow_flag)
        else $error("timer0 flag not set on overflow");
    AST_EXT_SET: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
        ext_hit |=> ext_pin_irq_flag)
        else $error("external flag not set on edge");
    AST_TIMER0_COUNT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
        (timer0_overflow_flag && !wr_ctrl) |=> timer0_overflow_flag)
        else $error("timer0 flag dropped without write");
    AST_TAKEN: assert property (@(posedge ref_clk) disable iff (rst) // RULE_17
        irq_taken |=> !global_irq_enable && !irq_req)
        else $error("global enable not cleared on taken interrupt");
    AST_RETURN: assert property (@(posedge ref_clk) disable iff (rst) // RULE_18
        (return_from_interrupt && !irq_taken) |=> global_irq_enable)
        else $error("global enable not restored on return");
    AST_TWO_BIT4: assert property (@(posedge ref_clk) disable iff (rst) // RULE_15
        !peripheral_enable_two[4])
        else $error("unimplemented enable bit became set");
    AST_SUMMARY: assert property (@(posedge ref_clk) disable iff (rst) // RULE_11
        (req.rd && req.addr == IDX_INTERRUPT_CONTROL) |=>
            reg_rdata[BIT_PCHG_FLAG] == $past(pin_change_summary_flag))
        else $error("summary flag read mismatch");
    AST_PENDING: assert property (@(posedge ref_clk) disable iff (rst) // RULE_20
        (global_irq_enable && ctrl[BIT_TIMER0_COUNT_EN] && timer0_overflow_flag && !irq_taken
         && !wr_ctrl) |=> irq_req)
        else $error("pending timer0 interrupt not requested");

    // Sticky external flag, timer0 set-over-clear and rising edge select
    AST_EXT_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
        (ext_pin_irq_flag && !wr_ctrl) |=> ext_pin_irq_flag)
        else $error("external flag dropped without write");
    AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
        (timer0_ovf && wr_ctrl) |=> timer0_overflow_flag)
        else $error("clear write beat timer0 overflow");
    AST_RISE_EDGE: assert property (@(posedge ref_clk) disable iff (rst) // RULE_19
        (ext_pin_edge_select && $rose(ext_pin)) |=> ext_pin_irq_flag)
        else $error("rising edge did not set external flag");

    // Register contents and read view
    AST_SUMMARY_CLEAR: assert property (@(posedge ref_clk) disable iff (rst) // RULE_12
        (req.rd && req.addr == IDX_INTERRUPT_CONTROL && per_pin_change_flags == '0) |=>
            !reg_rdata[BIT_PCHG_FLAG])
        else $error("summary flag read set with no pin flags");
    AST_TWO_READ: assert property (@(posedge ref_clk) disable iff (rst) // RULE_15
        (req.rd && req.addr == IDX_PERIPHERAL_ENABLE_TWO) |=> !reg_rdata[4])
        else $error("unimplemented enable bit read as one");
    AST_ONE_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RULE_13
        wr_one |=> peripheral_enable_one == $past(reg_wdata))
        else $error("first peripheral enable write lost");
    AST_TWO_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // RULE_14
        wr_two |=> peripheral_enable_two == ($past(reg_wdata) & ENABLE_TWO_MASK))
        else $error("second peripheral enable write lost");

    // Request gating and vector address
    AST_ALL_GATED: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
        (!ctrl[BIT_TIMER0_COUNT_EN] && !ctrl[BIT_EXT_EN] && !ctrl[BIT_PCHG_EN]
         && !peripheral_group_enable && !wr_ctrl) |=> !irq_req)
        else $error("request raised with every source disabled");
    AST_GROUP_OPEN: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
        (global_irq_enable && peripheral_group_enable && periph_raw && !irq_taken
         && !wr_ctrl && !return_from_interrupt) |=> irq_req)
        else $error("enabled peripheral flag not requested");
    AST_VECTOR: assert property (@(posedge ref_clk) disable iff (rst) // RULE_17
        1'b1 |=> irq_vector == IRQ_VECTOR)
        else $error("vector address wrong");
endmodule // irq_ctrl
`default_nettype wire

/* rtl/irq_ctrl_pkg.sv */
// Purpose: Constants and types for the interrupt enable and flag control block
// Assumes: One 10 MHz clock, register port with read data one cycle after strobe
// Notes:   Register indices are plain word numbers on the local port
//
// What this block does
// RULE_01: Global enable gates every interrupt request
// RULE_02: Peripheral group enable gates peripheral interrupts
// RULE_03: Peripheral enables need group enable too
// RULE_04: Flags set regardless of any enable
// RULE_05: Software clears flags before setting enables
// RULE_06: Timer0 overflow sets sticky flag bit 2
// RULE_07: Bit 5 gates timer0 overflow flag
// RULE_08: Selected external edge sets sticky flag bit 1
// RULE_09: Bit 4 gates external pin flag
// RULE_10: Bit 3 gates pin change summary flag
// RULE_11: Summary flag is OR of per-pin flags
// RULE_12: Summary flag read only, clears with pins
// RULE_13: First peripheral enable register bit layout
// RULE_14: Second peripheral enable register bit layout
// RULE_15: Second register bit 4 reads zero always
// RULE_16: All implemented bits reset to zero
// RULE_17: Taking interrupt clears global enable, vector 0004h
// RULE_18: Return from interrupt sets global enable again
// RULE_19: Edge select picks rising or falling edge
// RULE_20: Flag held pending while global enable clear
// RULE_21: Request is combined gated OR of flags
package irq_ctrl_pkg;

    localparam logic [1:0] IDX_INTERRUPT_CONTROL = 2'h0;
    localparam logic [1:0] IDX_PERIPHERAL_ENABLE_ONE = 2'h1;
    localparam logic [1:0] IDX_PERIPHERAL_ENABLE_TWO = 2'h2;
    localparam logic [1:0] IDX_EDGE_CONFIG = 2'h3;

    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_GROUP_EN = 6;
    localparam int BIT_TIMER0_COUNT_EN = 5;
    localparam int BIT_EXT_EN = 4;
    localparam int BIT_PCHG_EN = 3;
    localparam int BIT_TIMER0_COUNT_FLAG = 2;
    localparam int BIT_EXT_FLAG = 1;
    localparam int BIT_PCHG_FLAG = 0;
    localparam int BIT_EDGE_SEL = 0;

    localparam logic [7:0] RESET_VALUE = 8'h00;
    localparam logic [7:0] ENABLE_TWO_MASK = 8'hef;
    localparam logic [15:0] IRQ_VECTOR = 16'h0004;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

endpackage

/* rtl/edge_detect.sv */
// Purpose: Selectable edge detector on a synchronous input
// Assumes: Input already synchronous to the clock
// Notes:   Previous sample resets to zero
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
    input  wire logic ref_clk,  // System clock
    input  wire logic rst,      // Async reset, active high
    input  wire logic sig,      // Sampled input
    input  wire logic rising,   // One selects rising edge
    output logic      hit       // One-cycle edge pulse
);
    logic prev;
    wire  rise_w = sig & ~prev;
    wire  fall_w = ~sig & prev;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev <= 1'b0;
        end else begin
            prev <= sig;
        end
    end

    // RULE_19: edge choice
    assign hit = rising ? rise_w : fall_w;
endmodule // edge_detect
`default_nettype wire

/* testbench/irq_core_model.sv */
// Purpose: Core model that accepts the combined request
// Assumes: One clock, all pulses one cycle long
// Notes:   LAT sets cycles from request to acceptance
`timescale 1ns/1ps
`default_nettype none
module irq_core_model #(
    parameter int LAT = 2  // Request to accept delay
) (
    input  wire logic ref_clk,              // System clock
    input  wire logic rst,                  // Async reset
    input  wire logic irq_req,              // Combined request
    input  wire logic ack_en,               // Core may accept
    input  wire logic ret_go,               // Leave the handler
    output logic      irq_taken,            // Accept pulse
    output logic      return_from_interrupt // Return pulse
);
    int wait_cnt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 0;
            irq_taken <= 1'b0;
            return_from_interrupt <= 1'b0;
        end else begin
            wait_cnt <= (irq_req && ack_en && !irq_taken) ? wait_cnt + 1 : 0;
            irq_taken <= irq_req && ack_en && !irq_taken && wait_cnt == LAT - 1;
            return_from_interrupt <= ret_go;
        end
    end
endmodule // irq_core_model
`default_nettype wire

/* testbench/irq_ctrl_test.sv */
// Purpose: Self-checking bench for the interrupt enable and flag bank
// Assumes: Read data stands in the cycle after the read strobe
// Notes:   Core model accepts requests only while ack_en is high
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_test;
    import irq_ctrl_pkg::*;
    logic        ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        timer0_ovf = 1'b0, ext_pin = 1'b0, ack_en = 1'b0, ret_go = 1'b0;
    logic [1:0]  reg_addr = 2'h0;
    logic [7:0]  reg_wdata = 8'h00, pchg = 8'h00, pf1 = 8'h00, pf2 = 8'h00;
    logic [7:0]  reg_rdata;
    logic        irq_req, irq_taken, return_from_interrupt;
    logic [15:0] irq_vector;
    int          fails = 0, num_checks = 0;
    irq_ctrl uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .timer0_ovf, .ext_pin, .per_pin_change_flags(pchg), .periph_flags_one(pf1),
        .periph_flags_two(pf2), .irq_taken, .return_from_interrupt, .irq_req, .irq_vector);
    irq_core_model #(.LAT(2)) core (.ref_clk, .rst, .irq_req, .ack_en, .ret_go,
        .irq_taken, .return_from_interrupt);
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk({8'h00, reg_rdata}, {8'h00, exp});
        @(posedge ref_clk);
        #1 chk({8'h00, reg_rdata}, 16'h0000);
    endtask
    // Request level after settling, bounded wait
    task automatic req(input logic v);
        int n;
        n = 0;
        repeat (2) @(posedge ref_clk);
        #1;
        while (irq_req !== v && n < 8) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk({15'h0, irq_req}, {15'h0, v});
        if (n == 8) test_done();
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) rd(2'(i), 8'h00);
        chk(irq_vector, IRQ_VECTOR);
        $display("test register reset done");
        wr(IDX_PERIPHERAL_ENABLE_TWO, 8'hff);
        rd(IDX_PERIPHERAL_ENABLE_TWO, 8'hef);
        wr(IDX_PERIPHERAL_ENABLE_ONE, 8'hff);
        rd(IDX_PERIPHERAL_ENABLE_ONE, 8'hff);
        pf1 <= 8'h01;
        wr(IDX_INTERRUPT_CONTROL, 8'h80);
        req(1'b0);
        wr(IDX_INTERRUPT_CONTROL, 8'h40);
        req(1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(IDX_INTERRUPT_CONTROL, 8'hc0);
            wr(IDX_PERIPHERAL_ENABLE_ONE, 8'h01 << i);
            pf1 <= 8'hff ^ (8'h01 << i);
            req(1'b0);
            pf1 <= 8'h01 << i;
            req(1'b1);
        end
        pf1 <= 8'h00;
        pf2 <= 8'h10;
        req(1'b0);
        pf2 <= 8'h08;
        req(1'b1);
        pf2 <= 8'h00;
        $display("test peripheral done");
        wr(IDX_INTERRUPT_CONTROL, 8'h89);
        rd(IDX_INTERRUPT_CONTROL, 8'h88);
        pchg <= 8'h80;
        req(1'b1);
        rd(IDX_INTERRUPT_CONTROL, 8'h89);
        pchg <= 8'h00;
        req(1'b0);
        $display("test pin change done");
        wr(IDX_INTERRUPT_CONTROL, 8'h00);
        @(posedge ref_clk) timer0_ovf <= 1'b1;
        @(posedge ref_clk) timer0_ovf <= 1'b0;
        rd(IDX_INTERRUPT_CONTROL, 8'h04);
        req(1'b0);
        wr(IDX_INTERRUPT_CONTROL, 8'ha4);
        req(1'b1);
        ack_en <= 1'b1;
        req(1'b0);
        rd(IDX_INTERRUPT_CONTROL, 8'h24);
        ack_en <= 1'b0;
        @(posedge ref_clk) ret_go <= 1'b1;
        @(posedge ref_clk) ret_go <= 1'b0;
        req(1'b1);
        wr(IDX_INTERRUPT_CONTROL, 8'ha0);
        req(1'b0);
        $display("test timer0 done");
        wr(IDX_EDGE_CONFIG, 8'h01);
        wr(IDX_INTERRUPT_CONTROL, 8'h90);
        ext_pin <= 1'b1;
        req(1'b1);
        rd(IDX_INTERRUPT_CONTROL, 8'h92);
        wr(IDX_INTERRUPT_CONTROL, 8'h90);
        ext_pin <= 1'b0;
        req(1'b0);
        wr(IDX_EDGE_CONFIG, 8'h00);
        ext_pin <= 1'b1;
        req(1'b0);
        ext_pin <= 1'b0;
        req(1'b1);
        $display("test external pin done");
        rst <= 1'b1;
        #1 chk(irq_vector, 16'h0000);
        @(posedge ref_clk) rst <= 1'b0;
        rd(IDX_INTERRUPT_CONTROL, 8'h00);
        rd(IDX_PERIPHERAL_ENABLE_ONE, 8'h00);
        $display("test second reset done");
        test_done();
    end
endmodule // irq_ctrl_test
`default_nettype wire
